// ---- ecap_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the config autoload block.
`ifndef ECAP_CFG_SVH
`define ECAP_CFG_SVH
`define ECAP_SIG_VALUE 8'hA5
`define ECAP_SIG_ADDR 9'h000
`define ECAP_MAC_FIRST 9'h001
`define ECAP_MAC_LAST 9'h006
`define ECAP_FS_ADDR 9'h007
`define ECAP_HS_ADDR 9'h008
`define ECAP_FLAGS_ADDR 9'h009
`define ECAP_MAXPWR_ADDR 9'h00C
`define ECAP_WAKE_ADDR 9'h01D
`define ECAP_LAST_ADDR 9'h1FF
`define ECAP_DEF_MAC 48'hFFFFFFFFFFFF
`define ECAP_DEF_FS 8'h01
`define ECAP_DEF_HS 8'h04
`define ECAP_DEF_FLAGS 8'h04
`define ECAP_DEF_MAXPWR 8'hFA
`define ECAP_FLAG_POWER 0
`define ECAP_FLAG_RWAKE 2
`define ECAP_REG_ADDR_LOW 8'h00
`define ECAP_REG_ADDR_HIGH 8'h04
`define ECAP_REG_STATUS 8'h08
`define ECAP_REG_CTRL 8'h0C
`define ECAP_CTRL_SOFT 0
`define ECAP_CTRL_WAKE_CLR 1
`define ECAP_CLK_NS 50
`define ECAP_WAKE_SHORT_NS 1500000
`define ECAP_WAKE_LONG_NS 150000000
`define ECAP_WAKE_SHORT_CYC (`ECAP_WAKE_SHORT_NS / `ECAP_CLK_NS)
`define ECAP_WAKE_LONG_CYC (`ECAP_WAKE_LONG_NS / `ECAP_CLK_NS)
`endif

// ---- ecap_pkg.sv ----
// Types shared by the config autoload block.
package ecap_pkg;
	// Loader states, one-hot.
	typedef enum logic [3:0] {
		ECAP_IDLE = 4'h1,
		ECAP_SIG = 4'h2,
		ECAP_DATA = 4'h4,
		ECAP_END = 4'h8
	} ecap_state_type;
	// Wake flag byte bits 7 down to 1, in that order.
	typedef struct packed {
		logic en;
		logic pulse;
		logic long_w;
		logic pol;
		logic push_pull;
		logic link_sel;
		logic pin_high;
	} ecap_wake_type;
	// Loaded configuration as seen by the USB and address logic.
	typedef struct packed {
		logic [47:0] mac;
		logic [7:0] fs_poll;
		logic [7:0] hs_poll;
		logic [7:0] flags;
		logic [7:0] max_power;
		logic [15:0] vendor_id;
		logic [15:0] product_id;
	} ecap_cfg_type;
endpackage

// ---- ecap_store.sv ----
// The 512-byte image store filled by the loader and read by the USB control logic.
`timescale 1ns/1ps
module ecap_store (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [8:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [8:0] rd_addr,
	output logic [7:0] rd_data
);
	// Flip-flop storage; contents are undefined until the first valid load.
	logic [7:0] mem_reg [512];

	// Write port, driven only by the loader.
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	// Registered read port, one cycle of latency.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data <= 8'h00;
		end
		else
		begin
			rd_data <= mem_reg[rd_addr];
		end
	end
endmodule // ecap_store

// ---- ecap_wake_drv.sv ----
// Wake output driver: level or pulse, polarity, buffer type and pin routing.
`timescale 1ns/1ps
`include "ecap_cfg.svh"
module ecap_wake_drv #(
	parameter int SHORT_CYC = 1,
	parameter int LONG_CYC = 1
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire ecap_pkg::ecap_wake_type cfg,
	input wire logic evt,
	input wire logic clr,
	input wire logic ext_phy,
	output logic int_o,
	output logic int_oe_b,
	output logic ext_o,
	output logic ext_oe_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic [21:0] cnt_reg; // Remaining pulse cycles.
	logic level_reg; // Latched level-mode wake.
	logic [21:0] width_w; // Chosen pulse width.
	logic start_w; // A new pulse begins.
	logic active_w; // Wake is being signalled.
	logic o_w; // Pin value.
	logic oe_b_w; // Pin enable, low drives.

	assign width_w = cfg.long_w ? 22'(LONG_CYC) : 22'(SHORT_CYC);
	// An event during a running pulse is absorbed rather than stretching it.
	assign start_w = evt & cfg.pulse & (cnt_reg == 22'h000000);
	assign active_w = cfg.en & (cfg.pulse ? (cnt_reg != 22'h000000) : level_reg);

	// Pulse counter.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_reg <= 22'h000000;
		end
		else if (start_w)
		begin
			cnt_reg <= width_w;
		end
		else if (cnt_reg != 22'h000000)
		begin
			cnt_reg <= cnt_reg - 22'h000001;
		end
	end

	// Level latch; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			level_reg <= 1'b0;
		end
		else
		begin
			level_reg <= (evt & ~cfg.pulse) | (level_reg & ~clr);
		end
	end

	// Pin value and enable from polarity and buffer type.
	always_comb
	begin
		if (!cfg.en)
		begin
			o_w = 1'b0; // Released pin.
			oe_b_w = 1'b1;
		end
		else if (cfg.push_pull)
		begin
			o_w = active_w ? cfg.pol : ~cfg.pol;
			oe_b_w = 1'b0;
		end
		else
		begin
			o_w = cfg.pol;
			oe_b_w = ~active_w;
		end
	end

	// Registered pins; only the pin of the chosen PHY mode is used.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_o <= 1'b0;
			int_oe_b <= 1'b1;
			ext_o <= 1'b0;
			ext_oe_b <= 1'b1;
		end
		else
		begin
			int_o <= ext_phy ? 1'b0 : o_w;
			int_oe_b <= ext_phy | oe_b_w;
			ext_o <= ext_phy ? o_w : 1'b0;
			ext_oe_b <= ~ext_phy | oe_b_w;
		end
	end

	wake_off_a:
		assert property (!cfg.en |=> int_oe_b && ext_oe_b) else $error("Wake pin driven while disabled.");
	wake_pol_a:
		assert property (active_w && !ext_phy |=> !int_oe_b && int_o == $past(cfg.pol))
		else $error("Wake level does not follow polarity.");
	push_pull_a:
		assert property (cfg.en && cfg.push_pull && !ext_phy |=> !int_oe_b) else $error("Push-pull pin not driven.");
	open_rel_a:
		assert property (cfg.en && !cfg.push_pull && !active_w && ext_phy |=> ext_oe_b)
		else $error("Open driver drives inactive level.");
	pulse_width_a:
		assert property (start_w |=> cnt_reg == $past(width_w)) else $error("Wake pulse width wrong.");
endmodule // ecap_wake_drv

// ---- ecap_loader.sv ----
// EEPROM configuration autoload with store, station address registers and wake output.
`timescale 1ns/1ps
`include "ecap_cfg.svh"
// What this block does
// - Polarity flag sets wake output active level.
// - Buffer flag picks open or push-pull driver.
// - Open driver drives only the active level.
// - Source flag picks magic frame or link up; link up is ignored when the external PHY is selected.
// - Pin ten sense flag sets detection level.
// - Wake disabled means other wake flags ignored.
// - Byte zero 0xA5 marks a programmed EEPROM.
// - Blank EEPROM leaves built-in default values.
// - Straps adjust the default configuration flags.
// - Each listed reset starts an EEPROM load.
// - First read fetches signature at address zero.
// - USB bus reset reloads only station address.
// - Valid image is copied into 512-byte store.
// - USB control logic reads store on demand.
// - Bad signature ends load, defaults stay.
// - PHY held disconnected until a full load finishes.
// - Enable flag routes wake events to wake pin.
// - Mode flag picks level or pulse signalling.
// - Length flag picks 1.5 ms or 150 ms.
module ecap_loader #(
	parameter int WAKE_SHORT_CYC = `ECAP_WAKE_SHORT_CYC, // Short pulse in cycles.
	parameter int WAKE_LONG_CYC = `ECAP_WAKE_LONG_CYC, // Long pulse in cycles.
	parameter logic [15:0] VENDOR_ID_DEF = 16'h1111, // Arbitrary value.
	parameter logic [15:0] PRODUCT_ID_DEF = 16'h2222 // Arbitrary value.
)(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	output logic EE_RD_REQ,
	output logic [8:0] EE_RD_ADDR,
	input wire logic EE_RD_ACK,
	input wire logic [7:0] EE_RD_DATA,
	input wire logic EXTERNAL_RESET_PIN_B,
	input wire logic USB_BUS_RESET,
	input wire logic POWER_METHOD_STRAP,
	input wire logic REMOTE_WAKE_STRAP,
	input wire logic [8:0] USB_CONTROL_LOGIC_RD_ADDR,
	output logic [7:0] USB_CONTROL_LOGIC_RD_DATA,
	output logic LOAD_DONE,
	output logic EEPROM_VALID,
	output logic PHY_DISCONNECT,
	output ecap_pkg::ecap_cfg_type LOADED_CFG,
	input wire logic PHY_CHOICE_PIN,
	input wire logic WAKE_PIN_TEN,
	input wire logic MAGIC_FRAME_EVT,
	input wire logic LINK_UP_EVT,
	output logic WAKE_OUT_INTERNAL_PHY_O,
	output logic WAKE_OUT_INTERNAL_PHY_OE_B,
	output logic WAKE_OUT_EXTERNAL_PHY_O,
	output logic WAKE_OUT_EXTERNAL_PHY_OE_B
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	ecap_pkg::ecap_state_type state_reg; // Loader state.
	logic [8:0] addr_reg; // EEPROM byte being read.
	logic full_reg; // Current load is a full load.
	logic ack_d_reg; // Byte handshake seen last cycle.
	logic full_pend_reg; // A full load is owed.
	logic mac_pend_reg; // An address-only load is owed.
	logic load_done_reg; // No load running.
	logic phy_disc_reg; // USB PHY held off.
	logic valid_reg; // Last full load saw the signature.
	ecap_pkg::ecap_cfg_type cfg_reg; // Loaded configuration.
	ecap_pkg::ecap_wake_type wake_reg; // Captured wake flags.
	logic wb_ack_reg; // Bus acknowledge.
	logic [31:0] wb_dat_reg; // Bus read data.
	logic [31:0] rd_mux_w; // Read data selection.
	logic wb_req_w; // Request accepted this cycle.
	logic wb_wr_w; // Write commits this cycle.
	logic soft_cmd_w; // Software reset command.
	logic wake_clr_w; // Software clears a level wake.
	logic start_full_w; // Full load begins.
	logic start_any_w; // Some load begins.
	logic sig_ack_w; // Signature byte arrives.
	logic data_ack_w; // Data byte arrives.
	logic sig_ok_w; // Signature matches.
	logic [8:0] last_w; // Last byte of this load.
	logic [2:0] mac_lane_w; // Address byte lane.
	logic store_we_w; // Store write.
	logic wake_lvl_w; // Combined wake condition.
	logic wake_lvl_reg; // Previous wake condition.

	// True when a bus address selects the given register.
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_off);
		hit = (adr == reg_off);
	endfunction

	assign start_full_w = (state_reg == ecap_pkg::ECAP_IDLE) & full_pend_reg;
	assign start_any_w = (state_reg == ecap_pkg::ECAP_IDLE) & (full_pend_reg | mac_pend_reg);
	assign sig_ack_w = (state_reg == ecap_pkg::ECAP_SIG) & EE_RD_ACK;
	assign data_ack_w = (state_reg == ecap_pkg::ECAP_DATA) & EE_RD_ACK;
	assign sig_ok_w = (EE_RD_DATA == `ECAP_SIG_VALUE);
	// Bus reset loads stop after the address bytes.
	assign last_w = full_reg ? `ECAP_LAST_ADDR : `ECAP_MAC_LAST;
	assign mac_lane_w = 3'(addr_reg - `ECAP_MAC_FIRST);

	// The request drops for one cycle after each byte so every byte is a fresh handshake.
	assign EE_RD_REQ = ((state_reg == ecap_pkg::ECAP_SIG) | (state_reg == ecap_pkg::ECAP_DATA)) & ~ack_d_reg;
	assign EE_RD_ADDR = addr_reg;

	// Loader sequence: signature first, then the remaining bytes.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_reg <= ecap_pkg::ECAP_IDLE;
			addr_reg <= 9'h000;
			full_reg <= 1'b1;
			ack_d_reg <= 1'b0;
		end
		else
		begin
			ack_d_reg <= EE_RD_ACK & ~ack_d_reg;
			unique case (state_reg)
				ecap_pkg::ECAP_IDLE:
				begin
					// Full loads take priority; they also refresh the address.
					if (start_any_w)
					begin
						state_reg <= ecap_pkg::ECAP_SIG;
						addr_reg <= `ECAP_SIG_ADDR;
						full_reg <= full_pend_reg;
					end
				end
				ecap_pkg::ECAP_SIG:
				begin
					if (EE_RD_ACK && sig_ok_w)
					begin
						state_reg <= ecap_pkg::ECAP_DATA;
						addr_reg <= `ECAP_MAC_FIRST;
					end
					else if (EE_RD_ACK)
					begin
						state_reg <= ecap_pkg::ECAP_END;
					end
				end
				ecap_pkg::ECAP_DATA:
				begin
					if (EE_RD_ACK && addr_reg == last_w)
					begin
						state_reg <= ecap_pkg::ECAP_END;
					end
					else if (EE_RD_ACK)
					begin
						addr_reg <= addr_reg + 9'h001;
					end
				end
				ecap_pkg::ECAP_END:
				begin
					state_reg <= ecap_pkg::ECAP_IDLE;
				end
				default:
				begin
					state_reg <= ecap_pkg::ECAP_IDLE;
				end
			endcase
		end
	end

	// Load triggers. Power-on and the reset input leave a full load owed, and a new
	// trigger in the cycle its load starts is kept for another load.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			full_pend_reg <= 1'b1;
			mac_pend_reg <= 1'b0;
		end
		else
		begin
			full_pend_reg <= ~EXTERNAL_RESET_PIN_B | soft_cmd_w | (full_pend_reg & ~start_full_w);
			mac_pend_reg <= USB_BUS_RESET | (mac_pend_reg & ~start_any_w);
		end
	end

	// Completion and attach gating.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			load_done_reg <= 1'b0;
			phy_disc_reg <= 1'b1;
		end
		else if (start_any_w)
		begin
			load_done_reg <= 1'b0;
			phy_disc_reg <= phy_disc_reg | full_pend_reg;
		end
		else if (state_reg == ecap_pkg::ECAP_END)
		begin
			load_done_reg <= 1'b1;
			phy_disc_reg <= 1'b0;
		end
	end

	// Configuration: defaults at each full load, then overwritten by a valid image.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cfg_reg <= {`ECAP_DEF_MAC, `ECAP_DEF_FS, `ECAP_DEF_HS, `ECAP_DEF_FLAGS,
				`ECAP_DEF_MAXPWR, VENDOR_ID_DEF, PRODUCT_ID_DEF};
			wake_reg <= '0;
			valid_reg <= 1'b0;
		end
		else
		begin
			// Driver writes, used when no image supplied an address.
			if (wb_wr_w && hit(ADR_I, `ECAP_REG_ADDR_LOW))
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (SEL_I[i])
					begin
						cfg_reg.mac[8 * i +: 8] <= DAT_I[8 * i +: 8];
					end
				end
			end
			if (wb_wr_w && hit(ADR_I, `ECAP_REG_ADDR_HIGH) && SEL_I[0])
			begin
				cfg_reg.mac[39:32] <= DAT_I[7:0];
			end
			if (wb_wr_w && hit(ADR_I, `ECAP_REG_ADDR_HIGH) && SEL_I[1])
			begin
				cfg_reg.mac[47:40] <= DAT_I[15:8];
			end
			if (start_full_w)
			begin
				cfg_reg.mac <= `ECAP_DEF_MAC;
				cfg_reg.fs_poll <= `ECAP_DEF_FS;
				cfg_reg.hs_poll <= `ECAP_DEF_HS;
				cfg_reg.max_power <= `ECAP_DEF_MAXPWR;
				cfg_reg.vendor_id <= VENDOR_ID_DEF;
				cfg_reg.product_id <= PRODUCT_ID_DEF;
				// Straps are caught here, after reset release, not under the reset.
				cfg_reg.flags <= `ECAP_DEF_FLAGS;
				cfg_reg.flags[`ECAP_FLAG_POWER] <= POWER_METHOD_STRAP;
				cfg_reg.flags[`ECAP_FLAG_RWAKE] <= REMOTE_WAKE_STRAP;
				wake_reg <= '0;
				valid_reg <= 1'b0;
			end
			if (sig_ack_w && full_reg)
			begin
				valid_reg <= sig_ok_w;
			end
			if (data_ack_w && addr_reg <= `ECAP_MAC_LAST)
			begin
				cfg_reg.mac[{mac_lane_w, 3'b000} +: 8] <= EE_RD_DATA;
			end
			if (data_ack_w && full_reg)
			begin
				case (addr_reg)
					`ECAP_FS_ADDR: cfg_reg.fs_poll <= EE_RD_DATA;
					`ECAP_HS_ADDR: cfg_reg.hs_poll <= EE_RD_DATA;
					`ECAP_FLAGS_ADDR: cfg_reg.flags <= EE_RD_DATA;
					`ECAP_MAXPWR_ADDR: cfg_reg.max_power <= EE_RD_DATA;
					`ECAP_WAKE_ADDR: wake_reg <= ecap_pkg::ecap_wake_type'(EE_RD_DATA[7:1]);
					default: ;
				endcase
			end
		end
	end

	assign LOADED_CFG = cfg_reg;
	assign EEPROM_VALID = valid_reg;
	assign LOAD_DONE = load_done_reg;
	assign PHY_DISCONNECT = phy_disc_reg;

	// The signature byte and all bytes after it go into the store on a full load whose signature matches.
	assign store_we_w = full_reg & (data_ack_w | (sig_ack_w & sig_ok_w));

	ecap_store u_store (
		.clk(CLK),
		.rst_b(RST_B),
		.wr_en(store_we_w),
		.wr_addr(addr_reg),
		.wr_data(EE_RD_DATA),
		.rd_addr(USB_CONTROL_LOGIC_RD_ADDR),
		.rd_data(USB_CONTROL_LOGIC_RD_DATA)
	);

	// Bus slave. Requests wait while a load runs so software never sees half-loaded state.
	// A load that starts at the same edge also refuses the request, so no write lands inside a load.
	assign wb_req_w = CYC_I & STB_I & ~wb_ack_reg & load_done_reg & ~start_any_w;
	assign wb_wr_w = CYC_I & STB_I & WE_I & wb_ack_reg;
	assign soft_cmd_w = wb_wr_w & hit(ADR_I, `ECAP_REG_CTRL) & SEL_I[0] & DAT_I[`ECAP_CTRL_SOFT];
	assign wake_clr_w = wb_wr_w & hit(ADR_I, `ECAP_REG_CTRL) & SEL_I[0] & DAT_I[`ECAP_CTRL_WAKE_CLR];

	// Read selection; unmapped offsets read zero.
	always_comb
	begin
		rd_mux_w = 32'h00000000;
		if (hit(ADR_I, `ECAP_REG_ADDR_LOW))
		begin
			rd_mux_w = cfg_reg.mac[31:0];
		end
		else if (hit(ADR_I, `ECAP_REG_ADDR_HIGH))
		begin
			rd_mux_w = {16'h0000, cfg_reg.mac[47:32]};
		end
		else if (hit(ADR_I, `ECAP_REG_STATUS))
		begin
			rd_mux_w = {16'h0000, wake_reg, 1'b0, 4'h0, phy_disc_reg,
				~load_done_reg, valid_reg, load_done_reg};
		end
	end

	// Registered acknowledge, one cycle after the request is taken.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h00000000;
		end
		else
		begin
			wb_ack_reg <= wb_req_w;
			if (wb_req_w && !WE_I)
			begin
				wb_dat_reg <= rd_mux_w;
			end
		end
	end

	assign ACK_O = wb_ack_reg;
	assign DAT_O = wb_dat_reg;

	// Wake condition: pin ten at its sense level, or the chosen network source.
	// Link up is not a source when the external PHY is selected.
	assign wake_lvl_w = wake_reg.en & ((WAKE_PIN_TEN == wake_reg.pin_high)
		| (wake_reg.link_sel ? (LINK_UP_EVT & ~PHY_CHOICE_PIN) : MAGIC_FRAME_EVT));

	// Edge of the wake condition, so a held pin gives one event.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			wake_lvl_reg <= 1'b0;
		end
		else
		begin
			wake_lvl_reg <= wake_lvl_w;
		end
	end

	ecap_wake_drv #(
		.SHORT_CYC(WAKE_SHORT_CYC),
		.LONG_CYC(WAKE_LONG_CYC)
	) u_wake (
		.clk(CLK),
		.rst_b(RST_B),
		.cfg(wake_reg),
		.evt(wake_lvl_w & ~wake_lvl_reg),
		.clr(wake_clr_w),
		.ext_phy(PHY_CHOICE_PIN),
		.int_o(WAKE_OUT_INTERNAL_PHY_O),
		.int_oe_b(WAKE_OUT_INTERNAL_PHY_OE_B),
		.ext_o(WAKE_OUT_EXTERNAL_PHY_O),
		.ext_oe_b(WAKE_OUT_EXTERNAL_PHY_OE_B)
	);

	phy_held_a:
		assert property (full_reg && state_reg != ecap_pkg::ECAP_IDLE |-> PHY_DISCONNECT)
		else $error("PHY released during a full load.");
	sig_first_a:
		assert property ($rose(state_reg == ecap_pkg::ECAP_SIG) |-> EE_RD_REQ && EE_RD_ADDR == `ECAP_SIG_ADDR)
		else $error("First read is not the signature byte.");
	sig_valid_a:
		assert property (sig_ack_w && full_reg |=> EEPROM_VALID == ($past(EE_RD_DATA) == `ECAP_SIG_VALUE))
		else $error("Valid flag does not follow signature.");
	bad_sig_a:
		assert property (sig_ack_w && !sig_ok_w |=> state_reg == ecap_pkg::ECAP_END ##1 LOAD_DONE)
		else $error("Load did not stop on bad signature.");
	mac_only_a:
		assert property (state_reg == ecap_pkg::ECAP_DATA && !full_reg |-> EE_RD_ADDR <= `ECAP_MAC_LAST)
		else $error("Bus reset load read past the address.");
	defaults_a:
		assert property (start_full_w |=> cfg_reg.fs_poll == `ECAP_DEF_FS && cfg_reg.hs_poll == `ECAP_DEF_HS
			&& cfg_reg.max_power == `ECAP_DEF_MAXPWR && cfg_reg.mac == `ECAP_DEF_MAC)
		else $error("Defaults not applied at load start.");
	strap_a:
		assert property (start_full_w |=> cfg_reg.flags[`ECAP_FLAG_POWER] == $past(POWER_METHOD_STRAP)
			&& cfg_reg.flags[`ECAP_FLAG_RWAKE] == $past(REMOTE_WAKE_STRAP))
		else $error("Straps not folded into flags.");
	copy_a:
		assert property (data_ack_w && full_reg && addr_reg != `ECAP_LAST_ADDR
			|=> state_reg == ecap_pkg::ECAP_DATA && EE_RD_ADDR == $past(EE_RD_ADDR) + 9'h001)
		else $error("Image copy skipped a byte.");
	soft_load_a:
		assert property (soft_cmd_w && state_reg == ecap_pkg::ECAP_IDLE && !mac_pend_reg && !full_pend_reg
			|=> ##1 state_reg == ecap_pkg::ECAP_SIG && full_reg)
		else $error("Soft reset did not start a load.");
	bus_gate_a:
		assert property (!load_done_reg |=> !ACK_O) else $error("Bus answered during a load.");
endmodule // ecap_loader

// ---- ecap_ee_model.sv ----
// Behavioural serial EEPROM byte port with a fixed image pattern.
`timescale 1ns/1ps
module ecap_ee_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req,
	input wire logic [8:0] addr,
	input wire logic [7:0] sig,
	input wire logic [7:0] wake,
	input wire logic [7:0] salt,
	input wire logic slow,
	output logic ack,
	output logic [7:0] data
);
	logic [1:0] wait_reg; // Cycles spent on the open request.
	// Answers after one or three waits; between answers the data lines toggle so stale data never looks valid.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wait_reg <= 2'h0;
			ack <= 1'b0;
			data <= 8'h00;
		end
		else
		begin
			ack <= 1'b0;
			data <= ~data;
			if (req && !ack && wait_reg == {slow, 1'b1})
			begin
				wait_reg <= 2'h0;
				ack <= 1'b1;
				data <= addr == 9'h000 ? sig : addr == 9'h01D ? wake : addr[7:0] ^ salt;
			end
			else if (req && !ack)
				wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule // ecap_ee_model

// ---- tb_ecap_loader.sv ----
// Self-checking bench for the config autoload block.
`timescale 1ns/1ps
module tb_ecap_loader;
	localparam logic [15:0] VID = 16'h0B0B; // Arbitrary value.
	localparam logic [15:0] PID = 16'h0C0C; // Arbitrary value.
	logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ee_req, ee_ack, ext_b = 1'b1;
	logic usb_rst = 1'b0, pwr = 1'b1, rwk = 1'b0, done, valid, disc, phy = 1'b0, pin10 = 1'b1;
	logic magic = 1'b0, link = 1'b0, io, ioe, eo, eoe, slow = 1'b0, dsc, pol;
	logic [7:0] adr = 8'h00, ee_data, ucl_data, sig = 8'h00, wake = 8'h00, salt = 8'h5A;
	logic [8:0] ee_addr, ucl_addr = 9'h000, last_a;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [1:0] sp, op;
	ecap_pkg::ecap_cfg_type cfg;
	int fail_count = 0, n_tests = 0, n_reads, k, cnt;
	logic [7:0] wk [6] = '{8'h98, 8'hC0, 8'hF4, 8'hC4, 8'hC2, 8'h7E};
	int ev [6] = '{0, 0, 1, 1, 2, 0};
	int want [6] = '{-1, 20, 50, 0, 20, 0};
	logic [5:0] ph = 6'b001010;
	assign sp = phy ? {eo, eoe} : {io, ioe};
	assign op = phy ? {io, ioe} : {eo, eoe};
	always #25 clk = ~clk;
	// Counts answered EEPROM reads and remembers the last address.
	always @(posedge clk)
	begin
		if (ee_ack === 1'b1)
		begin
			n_reads++;
			last_a = ee_addr;
		end
	end
	ecap_loader #(.WAKE_SHORT_CYC(20), .WAKE_LONG_CYC(50), .VENDOR_ID_DEF(VID), .PRODUCT_ID_DEF(PID)) DUT (
		.CLK(clk), .RST_B(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
		.DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .EE_RD_REQ(ee_req), .EE_RD_ADDR(ee_addr),
		.EE_RD_ACK(ee_ack), .EE_RD_DATA(ee_data), .EXTERNAL_RESET_PIN_B(ext_b), .USB_BUS_RESET(usb_rst),
		.POWER_METHOD_STRAP(pwr), .REMOTE_WAKE_STRAP(rwk), .USB_CONTROL_LOGIC_RD_ADDR(ucl_addr),
		.USB_CONTROL_LOGIC_RD_DATA(ucl_data), .LOAD_DONE(done), .EEPROM_VALID(valid), .PHY_DISCONNECT(disc),
		.LOADED_CFG(cfg),
		.PHY_CHOICE_PIN(phy), .WAKE_PIN_TEN(pin10), .MAGIC_FRAME_EVT(magic), .LINK_UP_EVT(link),
		.WAKE_OUT_INTERNAL_PHY_O(io), .WAKE_OUT_INTERNAL_PHY_OE_B(ioe),
		.WAKE_OUT_EXTERNAL_PHY_O(eo), .WAKE_OUT_EXTERNAL_PHY_OE_B(eoe));
	ecap_ee_model EE (.clk(clk), .rst_b(rst_b), .req(ee_req), .addr(ee_addr), .sig(sig), .wake(wake),
		.salt(salt), .slow(slow), .ack(ee_ack), .data(ee_data));
	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One classic Wishbone cycle; read data is taken at the acking edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		sel <= s;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Waits for a load to start and finish; notes whether the PHY was held off meanwhile.
	task automatic wait_load;
		for (int i = 0; i < 20 && done === 1'b1; i++) @(posedge clk);
		dsc = disc;
		for (int i = 0; i < 9000 && done !== 1'b1; i++) @(posedge clk);
		check(done, 1'b1);
	endtask
	// Triggers a load: 0 soft reset, 1 reset pin, 2 USB bus reset.
	task automatic trig(input int how);
		n_reads = 0;
		if (how == 0)
			wb(1'b1, 8'h0C, 32'h0000_0001, 4'hF);
		else
		begin
			@(posedge clk);
			ext_b <= (how != 1);
			usb_rst <= (how == 2);
			@(posedge clk);
			ext_b <= 1'b1;
			usb_rst <= 1'b0;
		end
		wait_load;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog: the tests need about 16000 cycles.
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		print_verdict;
	end
	initial
	begin
		repeat (16) @(posedge clk);
		check(cfg.mac, 48'hFFFFFFFFFFFF);
		check(disc, 1'b1);
		rst_b <= 1'b1;
		wait_load;
		check({valid, n_reads[7:0], last_a}, {1'b0, 8'h01, 9'h000});
		check({cfg.fs_poll, cfg.hs_poll, cfg.flags, cfg.max_power}, 32'h010401FA);
		check({cfg.vendor_id, cfg.product_id, disc}, {VID, PID, 1'b0});
		$display("end of test: blank image");
		// The driver programs the station address; only lane 0 of the high word is enabled.
		wb(1'b1, 8'h00, 32'hA1B2C3D4, 4'hF);
		wb(1'b1, 8'h04, 32'hFFFF5566, 4'h1);
		// The write lands at the acking edge, so the new address is looked at one edge later.
		@(posedge clk);
		check(cfg.mac, 48'hFF66A1B2C3D4);
		wb(1'b0, 8'h04, 32'h0, 4'hF);
		check(rd, 32'h0000FF66);
		wb(1'b0, 8'h10, 32'h0, 4'hF);
		check(rd, 32'h0);
		$display("end of test: address registers");
		sig <= 8'hA5;
		wake <= 8'h98;
		slow <= 1'b1;
		trig(0);
		check({dsc, valid, n_reads[9:0], last_a}, {2'b11, 10'h200, 9'h1FF});
		check(cfg.mac, 48'h060504030201 ^ {6{8'h5A}});
		check({cfg.fs_poll, cfg.hs_poll, cfg.flags, cfg.max_power}, 32'h5D525356);
		for (k = 0; k < 512; k += 29)
		begin
			ucl_addr <= k[8:0];
			repeat (2) @(posedge clk);
			check(ucl_data, k == 0 ? 8'hA5 : k == 29 ? 8'h98 : k[7:0] ^ 8'h5A);
		end
		wb(1'b0, 8'h08, 32'h0, 4'hF);
		check({rd[15:8], rd[3:0]}, {8'h98, 4'b0011});
		$display("end of test: full load");
		salt <= 8'h33;
		slow <= 1'b0;
		trig(2);
		check({n_reads[7:0], last_a}, {8'h07, 9'h006});
		check(cfg.mac, 48'h060504030201 ^ {6{8'h33}});
		check({cfg.fs_poll, cfg.max_power, valid}, {8'h5D, 8'h56, 1'b1});
		$display("end of test: bus reset load");
		// Each wake case loads its flag byte, fires one event and counts active cycles on the pin.
		for (k = 0; k < 6; k++)
		begin
			phy <= ph[k];
			pin10 <= ~wk[k][1];
			wake <= wk[k];
			pol = wk[k][4];
			trig(k % 2);
			check(n_reads, 512);
			repeat (3) @(posedge clk);
			check(sp, !wk[k][7] ? 2'b01 : wk[k][3] ? {~pol, 1'b0} : {pol, 1'b1});
			magic <= (ev[k] == 0);
			link <= (ev[k] == 1);
			if (ev[k] == 2)
				pin10 <= wk[k][1];
			@(posedge clk);
			magic <= 1'b0;
			link <= 1'b0;
			pin10 <= ~wk[k][1];
			cnt = 0;
			repeat (80)
			begin
				@(posedge clk);
				if (sp === {pol, 1'b0})
					cnt++;
			end
			check(op, 2'b01);
			if (want[k] >= 0)
				check(64'(cnt), 64'(want[k]));
			else
			begin
				check(cnt > 70, 1'b1);
				wb(1'b1, 8'h0C, 32'h0000_0002, 4'hF);
				repeat (3) @(posedge clk);
				check(sp, {~pol, 1'b0});
			end
			$display("end of test: wake case %0d", k);
		end
		print_verdict;
	end
endmodule // tb_ecap_loader
